// *** bench/hvd_dram_model.sv ***
// behavioural random port of the dual port video dram
`timescale 1ns/100ps
`default_nettype none
module hvd_dram_model (
  input  wire hvd_pkg::hvd_pins_s i_pins,
  input  wire logic [15:0]        i_line,
  output logic      [15:0]        o_drv,
  output logic      [1:0]         o_en
);
  import hvd_pkg::*;
  logic [15:0] mem [262144];                   // cell array, one word each
  logic [15:0] color, wmask, msk, rdq;         // registers and latched read word
  logic [8:0]  row, col;                       // latched addresses
  logic [7:0]  stop;                           // stop register
  logic        newm, xfer, rdok, regset, blk, cok;
  logic [1:0]  ben;                            // byte enables low at row fall
  // masked word update
  task automatic put(input logic [17:0] a, input logic [15:0] d, input logic [15:0] m);
    mem[a] = (d & m) | (mem[a] & ~m);
  endtask : put
  // write enabled bytes, or eight columns of a block
  task automatic wr_bytes(input logic [1:0] b);
    if (blk) begin
      for (int n = 0; n < 8; n++)
        put({row, col[8:3], n[2:0]}, color, msk & {{8{b[1] & i_line[n+8]}}, {8{b[0] & i_line[n]}}});
    end else if (b != 2'b00) begin
      put({row, col}, i_line, msk & {{8{b[1]}}, {8{b[0]}}});
    end
  endtask : wr_bytes
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    {newm, cok, stop, color, wmask, rdq} = '0;
  end
  // cycle decode at row fall
  always @(negedge i_pins.ras_n) begin
    if (!i_pins.cas_n) begin
      if (!i_pins.special_function_select) begin
        stop = 8'hFF;
        newm = 1'b1;
      end
    end else begin
      row  = i_pins.addr;
      xfer = !i_pins.transfer_or_output_enable_n;
      rdok = !i_pins.special_function_select;
      ben  = ~{i_pins.upper_byte_write_enable_n, i_pins.lower_byte_write_enable_n};
      msk  = (ben == 2'b00) ? 16'hFFFF : newm ? i_line : wmask;
      regset = i_pins.special_function_select && ben == 2'b00;
      if (i_pins.special_function_select && ben != 2'b00) begin
        for (int c = 0; c < 512; c++)
          put({row, c[8:0]}, color, msk & {{8{ben[1]}}, {8{ben[0]}}});
      end
    end
  end
  // column latch, register set and early write at column fall
  always @(negedge i_pins.cas_n) if (!i_pins.ras_n) begin
    col = i_pins.addr;
    cok = 1'b1;
    rdq = mem[{row, col}];
    blk = i_pins.special_function_select && !regset;
    if (regset && i_pins.special_function_select) color = i_line;
    else if (regset) begin
      wmask = i_line;
      newm  = 1'b0;
    end else wr_bytes(~{i_pins.upper_byte_write_enable_n, i_pins.lower_byte_write_enable_n});
  end
  // late write per byte
  always @(negedge i_pins.upper_byte_write_enable_n)
    if (!i_pins.ras_n && !i_pins.cas_n) wr_bytes(2'b10);
  always @(negedge i_pins.lower_byte_write_enable_n)
    if (!i_pins.ras_n && !i_pins.cas_n) wr_bytes(2'b01);
  always @(posedge i_pins.ras_n) cok = 1'b0;
  // read drive; a released byte shows the inverse of the last word
  assign o_en[1] = cok && rdok && !xfer && !i_pins.transfer_or_output_enable_n
                   && !(i_pins.ras_n && i_pins.cas_n) && i_pins.upper_byte_write_enable_n;
  assign o_en[0] = cok && rdok && !xfer && !i_pins.transfer_or_output_enable_n
                   && !(i_pins.ras_n && i_pins.cas_n) && i_pins.lower_byte_write_enable_n;
  assign o_drv = {o_en[1] ? rdq[15:8] : ~rdq[15:8], o_en[0] ? rdq[7:0] : ~rdq[7:0]};
endmodule : hvd_dram_model
`default_nettype wire

// *** bench/tb_hvd_ctrl.sv ***
// self-checking bench of the video dram host controller
`timescale 1ns/100ps
`default_nettype none
module tb_hvd_ctrl;
  import hvd_pkg::*;
  logic        i_core_clk, i_rst_n, i_wr, i_rd;
  logic [3:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, rv;
  logic [15:0] i_dq, drv;
  logic [1:0]  den;
  hvd_pins_s   o_pins;
  hvd_dq_s     o_dq;
  int          fails, compares;
  hvd_ctrl dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pins(o_pins), .o_dq(o_dq), .i_dq(i_dq));
  hvd_dram_model dev (.i_pins(o_pins), .i_line(i_dq), .o_drv(drv), .o_en(den));
  // line level: controller drive wins, else what the device shows
  assign i_dq = o_dq.oe ? o_dq.data : drv;
  initial i_core_clk = 1'b0;
  always #50 i_core_clk = ~i_core_clk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  // both parties driving the lines at once
  always @(posedge i_core_clk)
    if (i_rst_n && o_dq.oe === 1'b1 && den !== 2'b00) check("bus clash", 1, 0);
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  // start a command and poll busy under a bound
  task automatic cmd(input logic [17:0] a, input logic [15:0] d, input logic [7:0] c);
    wr(4'h1, {14'h0000, a});
    wr(4'h2, {16'h0000, d});
    wr(4'h0, {24'h000000, c});
    for (int n = 0; n < 100; n++) begin
      rd(4'h5, rv);
      // an open page shows busy yet takes the next column command
      if (rv[0] === 1'b0 || rv[5] === 1'b1) return;
    end
    check("busy", 1, 0);
    complete_run();
  endtask : cmd
  task automatic rdw(input logic [17:0] a, input logic [7:0] c);
    cmd(a, 16'h0000, c);
    rd(4'h4, rv);
  endtask : rdw
  task automatic t_reset;
    check("idle strobes", {o_pins[14:10], o_dq.oe}, 6'h3E);
    rd(4'h5, rv);
    check("status", rv, 0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_writes;
    cmd(18'h00A05, 16'h1234, 8'hC2);
    rdw(18'h00A05, 8'h01);
    check("early write", rv[15:0], 16'h1234);
    cmd(18'h00A05, 16'hABCD, 8'h83);
    rdw(18'h00A05, 8'h01);
    check("late upper", rv[15:0], 16'hAB34);
    cmd(18'h00A05, 16'h5A5A, 8'hC4);
    rdw(18'h00A05, 8'h01);
    check("rmw", rv[15:0], 16'h5A5A);
    $display("write test done");
  endtask : t_writes
  task automatic t_mask;
    cmd(18'h00003, 16'hFFFF, 8'h22);
    rd(4'h5, rv);
    check("mask refused", rv[1], 1);
    wr(4'h5, 32'h00000002);
    cmd(18'h00000, 16'h0FF0, 8'h08);
    rd(4'h5, rv);
    check("old loaded", rv[2], 1);
    cmd(18'h00003, 16'hFFFF, 8'hE2);
    rdw(18'h00003, 8'h01);
    check("old mask write", rv[15:0], 16'h0FF0);
    $display("mask test done");
  endtask : t_mask
  task automatic t_flash;
    cmd(18'h00000, 16'hC3C3, 8'h07);
    cmd(18'h00600, 16'h0000, 8'hC5);
    rdw(18'h00605, 8'h01);
    check("flash col", rv[15:0], 16'h03C0);
    rdw(18'h007FF, 8'h01);
    check("flash last", rv[15:0], 16'h03C0);
    $display("flash test done");
  endtask : t_flash
  task automatic t_block;
    logic [15:0] exp [3];
    exp = '{16'hC3C3, 16'h0000, 16'h00C3};
    cmd(18'h00810, 16'h0105, 8'hC6);
    for (int n = 0; n < 3; n++) begin
      rdw(18'h00810 + n, 8'h01);
      check("block col", rv[15:0], exp[n]);
    end
    $display("block test done");
  endtask : t_block
  task automatic t_refresh;
    cmd(18'h00000, 16'h0000, 8'h0A);
    check("stop", dev.stop, 8'hFF);
    rd(4'h5, rv);
    check("new method", rv[3], 1);
    wr(4'h3, 32'h000000FF);
    cmd(18'h00100, 16'hFFFF, 8'hE2);
    rdw(18'h00100, 8'h01);
    check("new mask write", rv[15:0], 16'h00FF);
    cmd(18'h00100, 16'h0000, 8'h0B);
    rdw(18'h00100, 8'h01);
    check("row refresh keeps", rv[15:0], 16'h00FF);
    $display("refresh test done");
  endtask : t_refresh
  task automatic t_page;
    cmd(18'h00A06, 16'h7777, 8'hC2);
    rdw(18'h00A05, 8'h11);
    check("page first", rv[15:0], 16'h5A5A);
    rdw(18'h00A06, 8'h11);
    check("page second", rv[15:0], 16'h7777);
    check("row held", o_pins.ras_n, 0);
    cmd(18'h00000, 16'h0000, 8'h0C);
    check("row closed", o_pins.ras_n, 1);
    $display("page test done");
  endtask : t_page
  task automatic t_refuse;
    cmd(18'h00000, 16'h0000, 8'h00);
    rd(4'h5, rv);
    check("err", rv[1], 1);
    wr(4'h5, 32'h00000002);
    rd(4'h5, rv);
    check("err clear", rv[1], 0);
    cmd(18'h00000, 16'h0000, 8'h0C);
    rd(4'h5, rv);
    check("close idle", rv[1:0], 2'b10);
    cmd(18'h00000, 16'h0000, 8'h08);
    rd(4'h5, rv);
    check("old method", rv[4], 0);
    cmd(18'h00000, 16'h0000, 8'h09);
    rd(4'h5, rv);
    check("new select", rv[4:3], 2'b11);
    rd(4'hF, rv);
    check("unmapped", rv, 0);
    $display("refusal test done");
  endtask : t_refuse
  initial begin
    {i_rst_n, i_wr, i_rd, i_addr, i_wdata} = '0;
    fails = 0;
    compares = 0;
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_writes();
    t_mask();
    t_flash();
    t_block();
    t_refresh();
    t_page();
    t_refuse();
    complete_run();
  end
endmodule : tb_hvd_ctrl
`default_nettype wire

// *** rtl/hvd_ctrl.sv ***
// host sequencer driving the random port of a dual port video dram
`include "hvd_params.svh"
`timescale 1ns/100ps
`default_nettype none
module hvd_ctrl (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire logic [3:0]        i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [31:0]       o_rdata,
  output var hvd_pkg::hvd_pins_s o_pins,
  output var hvd_pkg::hvd_dq_s   o_dq,
  input  wire logic [15:0]       i_dq
);
  import hvd_pkg::*;

  hvd_state_e  state;      // sequencer state
  logic [3:0]  cnt;        // wait counter inside a state
  hvd_cmd_e    cmd;        // command being run
  logic        page;       // keep row open afterwards
  logic        masked;     // write per bit requested
  logic [1:0]  bytes;      // {upper, lower} byte selects
  logic [17:0] adr;        // word address
  logic [15:0] wdat;       // write data or column select
  logic [15:0] mask;       // new mask data
  logic [15:0] rdat;       // captured read word
  logic        old_ok;     // mask register loaded
  logic        new_ok;     // new mask method selected
  logic        src_new;    // active method is new mask
  logic        err;        // sticky refusal flag
  logic [15:0] dq_s;       // synchronised data lines
  logic        start;      // control write while ready
  logic        accept;     // start that passes checks
  hvd_cmd_e    wcmd;       // command field of the write
  logic        need_mask;  // command needs a mask method
  logic        mask_ok;    // active mask method usable

  // true for commands that only run a column cycle
  function automatic logic is_col(input hvd_cmd_e c);
    is_col = (c == HVD_READ) || (c == HVD_WRE) || (c == HVD_WRL) ||
             (c == HVD_RMW) || (c == HVD_BLOCK);
  endfunction : is_col

  // true for commands whose data go in before the column fall
  function automatic logic is_early(input hvd_cmd_e c);
    is_early = (c == HVD_WRE) || (c == HVD_BLOCK) ||
               (c == HVD_COLOR) || (c == HVD_MSET) || (c == HVD_NSEL);
  endfunction : is_early

  // true for register set cycles
  function automatic logic is_rset(input hvd_cmd_e c);
    is_rset = (c == HVD_COLOR) || (c == HVD_MSET) || (c == HVD_NSEL);
  endfunction : is_rset

  // read data lines pass two flops before use
  hvd_sync #(
    .W (16)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    (i_dq),
    .o_sync     (dq_s)
  );

  // decode of a command write
  always_comb begin
    wcmd      = hvd_cmd_e'(i_wdata[`HVD_CTRL_CMD_HI:0]);
    start     = i_wr && (i_addr == `HVD_REG_CTRL) &&
                ((state == S_IDLE) || (state == S_OPEN));
    need_mask = i_wdata[`HVD_CTRL_MASK] || (wcmd == HVD_FLASH);
    mask_ok   = src_new ? new_ok : old_ok;
    accept    = start && (wcmd != HVD_NOP) &&
                !(need_mask && !mask_ok) &&
                !((state == S_OPEN) && !is_col(wcmd) && (wcmd != HVD_CLOSE)) &&
                !((state == S_IDLE) && (wcmd == HVD_CLOSE));
  end

  // software registers written directly
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      adr  <= 18'h00000;
      wdat <= 16'h0000;
      mask <= 16'h0000;
    end else if (i_wr) begin
      case (i_addr)
        `HVD_REG_ADDR:  adr  <= i_wdata[17:0];
        `HVD_REG_WDATA: wdat <= i_wdata[15:0];
        `HVD_REG_MASK:  mask <= i_wdata[15:0];
        default: ;
      endcase
    end
  end

  // command latch on an accepted start
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cmd    <= HVD_NOP;
      page   <= 1'b0;
      masked <= 1'b0;
      bytes  <= 2'b00;
    end else if (accept) begin
      cmd   <= wcmd;
      page  <= i_wdata[`HVD_CTRL_PAGE];
      bytes <= {i_wdata[`HVD_CTRL_UPPER], i_wdata[`HVD_CTRL_LOWER]};
      // page columns keep the mask chosen at the row fall
      if (state == S_IDLE)
        masked <= need_mask;
    end
  end

  // mask method tracking and sticky error
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      old_ok  <= 1'b0;
      new_ok  <= 1'b0;
      src_new <= 1'b0;
      err     <= 1'b0;
    end else begin
      if (accept && (wcmd == HVD_MSET)) begin
        old_ok  <= 1'b1;
        src_new <= 1'b0;
      end
      if (accept && ((wcmd == HVD_NSEL) || (wcmd == HVD_CBR))) begin
        new_ok  <= 1'b1;
        src_new <= 1'b1;
      end
      // a refusal in the clearing cycle still sets the flag
      if (start && !accept)
        err <= 1'b1;
      else if (i_wr && (i_addr == `HVD_REG_STAT) && i_wdata[`HVD_STAT_ERR])
        err <= 1'b0;
    end
  end

  // sequencer, drives every dram pin from flops
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state  <= S_IDLE;
      cnt    <= 4'h0;
      o_pins <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 9'h000};
      o_dq   <= '{1'b0, 16'h0000};
    end else begin
      case (state)
        // take a command and set up the row strobe fall
        S_IDLE: begin
          if (accept && (wcmd == HVD_CBR)) begin
            o_pins.cas_n <= 1'b0;
            o_pins.special_function_select <= 1'b0;
            state <= S_CBR;
          end else if (accept) begin
            o_pins.addr <= adr[`HVD_ROW_HI:`HVD_ROW_LO];
            o_pins.transfer_or_output_enable_n <= 1'b1;
            // select only for flash and register set, never read
            o_pins.special_function_select <=
              (wcmd == HVD_FLASH) || is_rset(wcmd);
            if (need_mask) begin
              o_pins.upper_byte_write_enable_n <= ~i_wdata[`HVD_CTRL_UPPER];
              o_pins.lower_byte_write_enable_n <= ~i_wdata[`HVD_CTRL_LOWER];
              o_dq <= '{src_new, mask};
            end else begin
              o_pins.upper_byte_write_enable_n <= 1'b1;
              o_pins.lower_byte_write_enable_n <= 1'b1;
            end
            state <= S_PRAS;
          end
        end
        // refresh: column strobe already low, now the row strobe
        S_CBR: begin
          o_pins.ras_n <= 1'b0;
          state        <= S_RAS;
        end
        // row strobe fall with the row and mode pins stable
        S_PRAS: begin
          o_pins.ras_n <= 1'b0;
          cnt          <= 4'(`HVD_TRANSFER_SELECT_HOLD_TIME_CYC);
          state        <= S_RAS;
        end
        // hold after the row fall, then set up the column
        S_RAS: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else if (!is_col(cmd) && !is_rset(cmd)) begin
            // flash and refresh need no column strobe
            state <= S_PRE;
          end else begin
            o_pins.addr <= adr[`HVD_COL_HI:0];
            o_pins.special_function_select <=
              (cmd == HVD_BLOCK) || (cmd == HVD_COLOR);
            if (is_early(cmd)) begin
              // block write carries column selects on the lines
              o_dq <= '{1'b1, wdat};
              o_pins.upper_byte_write_enable_n <=
                is_rset(cmd) ? 1'b0 : ~bytes[1];
              o_pins.lower_byte_write_enable_n <=
                is_rset(cmd) ? 1'b0 : ~bytes[0];
            end else begin
              o_dq.oe <= 1'b0;
              o_pins.upper_byte_write_enable_n <= 1'b1;
              o_pins.lower_byte_write_enable_n <= 1'b1;
            end
            state <= S_PCAS;
          end
        end
        // page held open between column cycles
        S_OPEN: begin
          if (accept && (wcmd == HVD_CLOSE)) begin
            state <= S_PRE;
          end else if (accept) begin
            cnt   <= 4'h0;
            state <= S_RAS;
          end
        end
        // column strobe fall
        S_PCAS: begin
          o_pins.cas_n <= 1'b0;
          state        <= S_CAS;
        end
        // branch on the kind of column cycle
        S_CAS: begin
          case (cmd)
            HVD_READ, HVD_RMW: begin
              o_pins.transfer_or_output_enable_n <= 1'b0;
              cnt   <= 4'(`HVD_RD_CYC);
              state <= S_OEL;
            end
            HVD_WRL: begin
              // output enable stays high so the bus is ours
              o_dq  <= '{1'b1, wdat};
              state <= S_WEL;
            end
            default: state <= S_ECAS;
          endcase
        end
        // output enabled, wait for the synchronised word
        S_OEL: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else if (cmd == HVD_RMW) begin
            o_pins.transfer_or_output_enable_n <= 1'b1;
            cnt   <= 4'(`HVD_OUTPUT_TO_INPUT_TURNAROUND_CYC);
            state <= S_OEH;
          end else begin
            state <= S_ECAS;
          end
        end
        // bus turnaround before the modified word is driven
        S_OEH: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else begin
            o_dq  <= '{1'b1, wdat};
            state <= S_WEL;
          end
        end
        // late write enable fall captures the driven word
        S_WEL: begin
          o_pins.upper_byte_write_enable_n <= ~bytes[1];
          o_pins.lower_byte_write_enable_n <= ~bytes[0];
          state <= S_ECAS;
        end
        // end of a column cycle, keep or close the row
        S_ECAS: begin
          o_pins.cas_n <= 1'b1;
          o_pins.transfer_or_output_enable_n <= 1'b1;
          o_pins.upper_byte_write_enable_n <= 1'b1;
          o_pins.lower_byte_write_enable_n <= 1'b1;
          o_pins.special_function_select <= 1'b0;
          o_dq.oe <= 1'b0;
          state   <= page ? S_OPEN : S_PRE;
        end
        // precharge: every strobe high, bus released
        S_PRE: begin
          o_pins <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, o_pins.addr};
          o_dq.oe <= 1'b0;
          state   <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // capture of the read word at the end of the output wait
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n)
      rdat <= 16'h0000;
    else if ((state == S_OEL) && (cnt == 4'h0))
      rdat <= dq_s;
  end

  // read data stand in the cycle after the strobe only
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h00000000;
    end else if (!i_rd) begin
      o_rdata <= 32'h00000000;
    end else begin
      case (i_addr)
        `HVD_REG_ADDR:  o_rdata <= {14'h0000, adr};
        `HVD_REG_WDATA: o_rdata <= {16'h0000, wdat};
        `HVD_REG_MASK:  o_rdata <= {16'h0000, mask};
        `HVD_REG_RDATA: o_rdata <= {16'h0000, rdat};
        `HVD_REG_STAT:  o_rdata <= {26'h0000000, (state == S_OPEN), src_new,
                                    new_ok, old_ok, err, (state != S_IDLE)};
        default:        o_rdata <= 32'h00000000;
      endcase
    end
  end

  // checks on the pin sequences and on the refusal of mask use
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  property p_row_addr;
    $fell(o_pins.ras_n) && (cmd != HVD_CBR) |->
      o_pins.addr == adr[`HVD_ROW_HI:`HVD_ROW_LO];
  endproperty
  a_row_addr: assert property (p_row_addr) else $error("row address wrong");

  property p_col_addr;
    $fell(o_pins.cas_n) && !o_pins.ras_n |-> o_pins.addr == adr[`HVD_COL_HI:0];
  endproperty
  a_col_addr: assert property (p_col_addr) else $error("column address wrong");

  property p_plain_we;
    $fell(o_pins.ras_n) && !masked && (cmd != HVD_CBR) |->
      o_pins.upper_byte_write_enable_n && o_pins.lower_byte_write_enable_n;
  endproperty
  a_plain_we: assert property (p_plain_we) else $error("write enable low at row");

  property p_read_toe;
    $fell(o_pins.ras_n) && (cmd == HVD_READ) |->
      o_pins.transfer_or_output_enable_n [*2] ##1 !o_pins.special_function_select;
  endproperty
  a_read_toe: assert property (p_read_toe) else $error("oe low too soon");

  property p_read_dsf;
    $fell(o_pins.ras_n) && (cmd == HVD_READ) |-> !o_pins.special_function_select;
  endproperty
  a_read_dsf: assert property (p_read_dsf) else $error("select high on read");

  sequence s_oe_up;
    $rose(o_pins.transfer_or_output_enable_n) && (cmd == HVD_RMW);
  endsequence
  sequence s_turn;
    !o_dq.oe [*2] ##1 o_dq.oe ##1 !o_pins.lower_byte_write_enable_n || !bytes[0];
  endsequence
  property p_rmw_turn;
    s_oe_up |-> s_turn;
  endproperty
  a_rmw_turn: assert property (p_rmw_turn) else $error("turnaround short");

  property p_refuse;
    start && need_mask && !mask_ok |=> err && (state == $past(state));
  endproperty
  a_refuse: assert property (p_refuse) else $error("mask use not refused");

  property p_early;
    $fell(o_pins.cas_n) && (cmd == HVD_WRE) |->
      o_dq.oe && (o_pins.lower_byte_write_enable_n == ~bytes[0]);
  endproperty
  a_early: assert property (p_early) else $error("early write late");

  property p_late;
    $fell(o_pins.cas_n) && (cmd == HVD_WRL) |->
      o_pins.transfer_or_output_enable_n ##2 o_dq.oe;
  endproperty
  a_late: assert property (p_late) else $error("late write order");

  property p_block_sel;
    $fell(o_pins.cas_n) && (cmd == HVD_BLOCK) |->
      o_dq.oe && (o_dq.data == wdat) && o_pins.special_function_select;
  endproperty
  a_block_sel: assert property (p_block_sel) else $error("column select missing");
endmodule : hvd_ctrl
`default_nettype wire

// *** rtl/hvd_params.svh ***
// constants of the video dram host controller: offsets, fields, timing
`ifndef HVD_PARAMS_SVH
`define HVD_PARAMS_SVH
// register word offsets on the software port
`define HVD_REG_CTRL     4'h0
`define HVD_REG_ADDR     4'h1
`define HVD_REG_WDATA    4'h2
`define HVD_REG_MASK     4'h3
`define HVD_REG_RDATA    4'h4
`define HVD_REG_STAT     4'h5
// control register fields
`define HVD_CTRL_CMD_HI  3
`define HVD_CTRL_PAGE    4
`define HVD_CTRL_MASK    5
`define HVD_CTRL_LOWER   6
`define HVD_CTRL_UPPER   7
// status register bits
`define HVD_STAT_BUSY    0
`define HVD_STAT_ERR     1
`define HVD_STAT_OLD     2
`define HVD_STAT_NEW     3
`define HVD_STAT_SRC     4
`define HVD_STAT_OPEN    5
// address split: row in the upper nine bits, column in the lower nine
`define HVD_ROW_HI       17
`define HVD_ROW_LO       9
`define HVD_COL_HI       8
// timing in ns and derived clock counts
`define HVD_CLK_NS       100
`define HVD_TRANSFER_SELECT_HOLD_TIME_NS      10
`define HVD_OUTPUT_TO_INPUT_TURNAROUND_NS      15
`define HVD_CEIL(ns)     ((((ns) + `HVD_CLK_NS - 1) / `HVD_CLK_NS) > 0 ? \
                          (((ns) + `HVD_CLK_NS - 1) / `HVD_CLK_NS) : 1)
`define HVD_TRANSFER_SELECT_HOLD_TIME_CYC     `HVD_CEIL(`HVD_TRANSFER_SELECT_HOLD_TIME_NS)
`define HVD_OUTPUT_TO_INPUT_TURNAROUND_CYC     `HVD_CEIL(`HVD_OUTPUT_TO_INPUT_TURNAROUND_NS)
// output enable low to capture: access plus two synchroniser stages
`define HVD_RD_CYC       3
`endif

// *** rtl/hvd_pkg.sv ***
// types of the video dram host controller
package hvd_pkg;
  // commands written to the control register
  typedef enum logic [3:0] {
    HVD_NOP   = 4'h0,
    HVD_READ  = 4'h1,
    HVD_WRE   = 4'h2,  // early write
    HVD_WRL   = 4'h3,  // late write
    HVD_RMW   = 4'h4,
    HVD_FLASH = 4'h5,
    HVD_BLOCK = 4'h6,
    HVD_COLOR = 4'h7,  // color register set
    HVD_MSET  = 4'h8,  // write mask register set
    HVD_NSEL  = 4'h9,  // new mask selection
    HVD_CBR   = 4'hA,  // refresh, always with reset
    HVD_RREF  = 4'hB,  // row only refresh
    HVD_CLOSE = 4'hC   // close an open page
  } hvd_cmd_e;
  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_CBR  = 4'h1,
    S_PRAS = 4'h2,
    S_RAS  = 4'h3,
    S_OPEN = 4'h4,
    S_PCAS = 4'h5,
    S_CAS  = 4'h6,
    S_OEL  = 4'h7,
    S_OEH  = 4'h8,
    S_WEL  = 4'h9,
    S_ECAS = 4'hA,
    S_PRE  = 4'hB
  } hvd_state_e;
  // strobe and address pins toward the dram
  typedef struct packed {
    logic       ras_n;
    logic       cas_n;
    logic       transfer_or_output_enable_n;
    logic       upper_byte_write_enable_n;
    logic       lower_byte_write_enable_n;
    logic       special_function_select;
    logic [8:0] addr;
  } hvd_pins_s;
  // driven side of the mask and data lines
  typedef struct packed {
    logic        oe;
    logic [15:0] data;
  } hvd_dq_s;
endpackage : hvd_pkg

// *** rtl/hvd_sync.sv ***
// two stage synchroniser for the mask and data lines
`timescale 1ns/100ps
`default_nettype none
module hvd_sync #(
  parameter int W = 16
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta;  // first stage, read only by the second
  // two flops in series
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule : hvd_sync
`default_nettype wire
